// ---- rtl/synth_pkg.sv ----
package synth_pkg;

  // ----------------------------------------------------------------
  // Serial programming word
  // ----------------------------------------------------------------
  localparam int WORD_W     = 17;
  localparam int VALUE_W    = 16;
  localparam int SWALLOW_W  = 6;
  localparam int MAIN_W     = 10;
  localparam int SWALLOW_LSB = 0;
  localparam int MAIN_LSB    = 6;

  // ----------------------------------------------------------------
  // Prescaler moduli and reset settings
  // ----------------------------------------------------------------
  localparam int          PRESC_W      = 7;
  localparam logic [6:0]  PRESC_LOW    = 7'h40;
  localparam logic [6:0]  PRESC_HIGH   = 7'h41;
  localparam logic [15:0] REF_RATIO_RST = 16'h0005;
  localparam logic [9:0]  MAIN_RST      = 10'h005;
  localparam logic [5:0]  SWALLOW_RST   = 6'h00;
  localparam logic        STANDBY_RST   = 1'b1;

  // ----------------------------------------------------------------
  // Synchronised pin bundle positions
  // ----------------------------------------------------------------
  localparam int PIN_N     = 5;
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LOAD  = 2;
  localparam int PIN_VCO   = 3;
  localparam int PIN_REF   = 4;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CONTROL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF  = 12'h004;
  localparam logic [11:0] REF_OFF     = 12'h008;
  localparam logic [11:0] VCO_OFF     = 12'h00c;

  localparam int CTL_FORCE_STANDBY = 0;
  localparam int CTL_PUMP_ENABLE   = 1;
  localparam logic [1:0] CONTROL_RST = 2'h2;

  localparam int ST_LOCK    = 0;
  localparam int ST_STANDBY = 1;
  localparam int ST_SELECT  = 2;
  localparam int ST_UP      = 3;
  localparam int ST_DOWN    = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       drive;
    logic       oe;
  } pump_t;

  typedef struct packed {
    logic [9:0] main;
    logic [5:0] swallow;
  } vco_setting_t;

  // True when one more step completes a cycle of the given ratio
  function automatic logic at_end(input logic [15:0] cnt, input logic [15:0] ratio);
    logic [16:0] nxt;
    nxt = {1'b0, cnt} + 17'h00001;
    return nxt >= {1'b0, ratio};
  endfunction

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Pins
  input  wire logic [W-1:0] din,
  // Synchronised view
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // Edge detection looks only at the second and third stages
  assign level = s2_ff;
  assign rise  = s2_ff & ~s3_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else if (ce)
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

endmodule

// ---- rtl/ratio_divider.sv ----
`timescale 1ns/1ns
module ratio_divider #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Control
  input  wire logic         clear,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  // Result
  output logic              done
);

  logic [W-1:0] cnt_ff;
  logic         done_ff;
  logic         wrap;

  assign wrap = synth_pkg::at_end(16'(cnt_ff), 16'(ratio));
  assign done = done_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (clear)
      begin
        cnt_ff  <= '0;
        done_ff <= 1'b0;
      end
      else if (tick)
      begin
        cnt_ff  <= wrap ? '0 : W'(cnt_ff + 1'b1);
        done_ff <= wrap;
      end
      else
        done_ff <= 1'b0;
    end
  end

endmodule

// ---- rtl/serial_pll_divider_control.sv ----
`timescale 1ns/1ns
module serial_pll_divider_control (
  // Clock, reset, enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Serial programming link
  input  wire logic          serial_clk,
  input  wire logic          serial_data,
  input  wire logic          load_strobe,
  // Frequency inputs
  input  wire logic          vco_input,
  input  wire logic          reference_oscillator_input,
  output logic               reference_inverter_output,
  // Loop outputs
  output synth_pkg::pump_t   pump_passive,
  output synth_pkg::pump_t   pump_active,
  output logic               lock_indicator_out,
  output logic               divided_vco_monitor,
  output logic               divided_reference_monitor,
  output logic               ext_pump_ref,
  output logic               ext_pump_vco
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [synth_pkg::PIN_N-1:0] pins;
  logic [synth_pkg::PIN_N-1:0] pin_lvl;
  logic [synth_pkg::PIN_N-1:0] pin_rise;

  assign pins[synth_pkg::PIN_SCLK]  = serial_clk;
  assign pins[synth_pkg::PIN_SDATA] = serial_data;
  assign pins[synth_pkg::PIN_LOAD]  = load_strobe;
  assign pins[synth_pkg::PIN_VCO]   = vco_input;
  assign pins[synth_pkg::PIN_REF]   = reference_oscillator_input;

  // Data and clock share the same delay, so data is sampled where it was set up
  pin_sync #(
    .W (synth_pkg::PIN_N)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (pins),
    .level   (pin_lvl),
    .rise    (pin_rise)
  );

  // ----------------------------------------------------------------
  // Serial shift register and setting latches
  // ----------------------------------------------------------------
  logic [synth_pkg::WORD_W-1:0]  shift_ff;
  logic [synth_pkg::VALUE_W-1:0] ref_ratio_ff;
  synth_pkg::vco_setting_t       vco_set_ff;
  logic                          standby_ff;
  logic                          select_ff;

  logic [synth_pkg::VALUE_W-1:0] value_word;
  logic                          select_bit;
  logic                          load_now;
  logic                          zero_word;
  synth_pkg::vco_setting_t       nxt_vco_set;

  // Last bit shifted in is the select bit; the value sits above it
  assign select_bit  = shift_ff[0];
  assign value_word  = shift_ff[synth_pkg::WORD_W-1:1];
  assign load_now    = pin_lvl[synth_pkg::PIN_LOAD];
  assign zero_word   = (value_word == 16'h0000);
  assign nxt_vco_set.swallow = value_word[synth_pkg::SWALLOW_LSB +: synth_pkg::SWALLOW_W];
  assign nxt_vco_set.main    = value_word[synth_pkg::MAIN_LSB +: synth_pkg::MAIN_W];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shift_ff <= '0;
    else if (ce && pin_rise[synth_pkg::PIN_SCLK])
      shift_ff <= {shift_ff[synth_pkg::WORD_W-2:0], pin_lvl[synth_pkg::PIN_SDATA]};
  end

  // Load is level sensitive: the latch follows the shifter while the strobe is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_ratio_ff       <= synth_pkg::REF_RATIO_RST;
      vco_set_ff.main    <= synth_pkg::MAIN_RST;
      vco_set_ff.swallow <= synth_pkg::SWALLOW_RST;
      standby_ff         <= synth_pkg::STANDBY_RST;
      select_ff          <= 1'b0;
    end
    else if (ce && load_now)
    begin
      if (select_bit)
        ref_ratio_ff <= value_word;
      else
        vco_set_ff <= nxt_vco_set;
      standby_ff <= zero_word;
      select_ff  <= select_bit;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] control_ff;
  logic       halted;
  logic       pump_en;

  assign halted  = standby_ff | control_ff[synth_pkg::CTL_FORCE_STANDBY];
  assign pump_en = control_ff[synth_pkg::CTL_PUMP_ENABLE] & ~halted;

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  logic ref_div;

  // Ratios below five are the host's to avoid; the counter stays safe anyway
  ratio_divider #(
    .W (synth_pkg::VALUE_W)
  ) u_ref_div (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (halted),
    .tick    (pin_rise[synth_pkg::PIN_REF]),
    .ratio   (ref_ratio_ff),
    .done    (ref_div)
  );

  // ----------------------------------------------------------------
  // VCO path: dual-modulus prescaler with swallow and main counters
  // ----------------------------------------------------------------
  logic [synth_pkg::MAIN_W-1:0]    main_cnt_ff;
  logic [synth_pkg::SWALLOW_W-1:0] swallow_cnt_ff;
  logic                            vco_div_ff;
  logic                            presc_done;
  logic                            swallowing;
  logic                            main_wrap;
  logic [synth_pkg::PRESC_W-1:0]   presc_ratio;

  assign swallowing  = swallow_cnt_ff < vco_set_ff.swallow;
  assign presc_ratio = swallowing ? synth_pkg::PRESC_HIGH : synth_pkg::PRESC_LOW;
  assign main_wrap   = synth_pkg::at_end(16'(main_cnt_ff), 16'(vco_set_ff.main));

  ratio_divider #(
    .W (synth_pkg::PRESC_W)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (halted),
    .tick    (pin_rise[synth_pkg::PIN_VCO]),
    .ratio   (presc_ratio),
    .done    (presc_done)
  );

  // Swallow cycles of 65 then main minus swallow cycles of 64: 64*N + A in total
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_cnt_ff    <= '0;
      swallow_cnt_ff <= '0;
      vco_div_ff     <= 1'b0;
    end
    else if (ce)
    begin
      if (halted)
      begin
        main_cnt_ff    <= '0;
        swallow_cnt_ff <= '0;
        vco_div_ff     <= 1'b0;
      end
      else if (presc_done)
      begin
        vco_div_ff <= main_wrap;
        if (main_wrap)
        begin
          main_cnt_ff    <= '0;
          swallow_cnt_ff <= '0;
        end
        else
        begin
          main_cnt_ff <= main_cnt_ff + 10'h001;
          if (swallowing)
            swallow_cnt_ff <= swallow_cnt_ff + 6'h01;
        end
      end
      else
        vco_div_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Phase/frequency detector
  // ----------------------------------------------------------------
  logic up_ff;
  logic dn_ff;
  logic nxt_up;
  logic nxt_dn;

  // Both flags set means the edges have met; clearing both leaves the pulse width
  assign nxt_up = (up_ff | ref_div) & ~((up_ff | ref_div) & (dn_ff | vco_div_ff));
  assign nxt_dn = (dn_ff | vco_div_ff) & ~((up_ff | ref_div) & (dn_ff | vco_div_ff));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
    end
    else if (ce)
    begin
      up_ff <= nxt_up & ~halted;
      dn_ff <= nxt_dn & ~halted;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  synth_pkg::pump_t nxt_passive;
  synth_pkg::pump_t nxt_active;
  synth_pkg::pump_t passive_ff;
  synth_pkg::pump_t active_ff;
  logic             lock_ff;
  logic             vmon_ff;
  logic             rmon_ff;
  logic             ext_ref_ff;
  logic             ext_vco_ff;
  logic             osc_inv_ff;

  assign nxt_passive.oe    = pump_en & (up_ff ^ dn_ff);
  assign nxt_passive.drive = up_ff;
  assign nxt_active.oe     = pump_en & (up_ff ^ dn_ff);
  assign nxt_active.drive  = dn_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      passive_ff <= '0;
      active_ff  <= '0;
      lock_ff    <= 1'b1;
      vmon_ff    <= 1'b0;
      rmon_ff    <= 1'b0;
      ext_ref_ff <= 1'b0;
      ext_vco_ff <= 1'b0;
      osc_inv_ff <= 1'b1;
    end
    else if (ce)
    begin
      passive_ff <= nxt_passive;
      active_ff  <= nxt_active;
      lock_ff    <= ~(up_ff | dn_ff);
      vmon_ff    <= vco_div_ff;
      rmon_ff    <= ref_div;
      ext_ref_ff <= up_ff;
      ext_vco_ff <= dn_ff;
      osc_inv_ff <= ~(pin_lvl[synth_pkg::PIN_REF] | halted);
    end
  end

  assign pump_passive              = passive_ff;
  assign pump_active               = active_ff;
  assign lock_indicator_out        = lock_ff;
  assign divided_vco_monitor       = vmon_ff;
  assign divided_reference_monitor = rmon_ff;
  assign ext_pump_ref              = ext_ref_ff;
  assign ext_pump_vco              = ext_vco_ff;
  assign reference_inverter_output = osc_inv_ff;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        access;
  logic        commit;
  logic        hit;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  // One wait state keeps every bus output registered
  assign access = psel & penable;
  assign commit = access & pready_ff;
  assign hit    = (paddr == synth_pkg::CONTROL_OFF) | (paddr == synth_pkg::STATUS_OFF) |
                  (paddr == synth_pkg::REF_OFF)     | (paddr == synth_pkg::VCO_OFF);

  assign status_word = {27'h0000000, dn_ff, up_ff, select_ff, halted, lock_ff};
  assign rd_mux = (paddr == synth_pkg::CONTROL_OFF) ? {30'h00000000, control_ff} :
                  (paddr == synth_pkg::STATUS_OFF)  ? status_word :
                  (paddr == synth_pkg::REF_OFF)     ? {16'h0000, ref_ratio_ff} :
                  (paddr == synth_pkg::VCO_OFF)     ? {16'h0000, vco_set_ff} :
                  32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else if (ce)
    begin
      pready_ff  <= access & ~pready_ff;
      pslverr_ff <= access & ~pready_ff & ~hit;
      prdata_ff  <= (access & ~pready_ff & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_ff <= synth_pkg::CONTROL_RST;
    else if (ce && commit && pwrite && paddr == synth_pkg::CONTROL_OFF)
      control_ff <= pwdata[1:0];
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

endmodule

// ---- dv/serial_pll_divider_control_props.sv ----
`timescale 1ns/1ns
module pll_ctl_props (
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             ce,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Serial link and sources
  input wire logic             serial_clk,
  input wire logic             serial_data,
  input wire logic             load_strobe,
  input wire logic             vco_input,
  input wire logic             reference_oscillator_input,
  input wire logic             reference_inverter_output,
  // Loop outputs
  input wire synth_pkg::pump_t pump_passive,
  input wire synth_pkg::pump_t pump_active,
  input wire logic             lock_indicator_out,
  input wire logic             divided_vco_monitor,
  input wire logic             divided_reference_monitor,
  input wire logic             ext_pump_ref,
  input wire logic             ext_pump_vco
);
  wire err_any = ext_pump_ref || ext_pump_vco;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------
  // Bus and loop relations
  // ------------------------------
  property p_apb_wait;
    pready |-> psel && penable && $past(penable) && !$past(pready);
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready outside second access cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_pump_passive;
    pump_passive.oe |-> err_any && (pump_passive.drive == ext_pump_ref);
  endproperty
  a_pump_passive: assert property (p_pump_passive) else $error("passive pump level wrong");
  property p_pump_float;
    !err_any |-> !pump_passive.oe && !pump_active.oe;
  endproperty
  a_pump_float: assert property (p_pump_float) else $error("pump driven with no error");
  property p_pump_active;
    pump_passive.oe || pump_active.oe |->
      pump_active.oe && pump_passive.oe && (pump_active.drive != pump_passive.drive);
  endproperty
  a_pump_active: assert property (p_pump_active) else $error("active pump polarity wrong");
  property p_ext_excl;
    ext_pump_ref |-> !ext_pump_vco;
  endproperty
  a_ext_excl: assert property (p_ext_excl) else $error("both external pump outputs high");
  property p_err_start;
    $rose(err_any) |-> $past(divided_vco_monitor) || $past(divided_reference_monitor);
  endproperty
  a_err_start: assert property (p_err_start) else $error("phase error without divider edge");
  property p_lock;
    !lock_indicator_out |-> err_any || $past(err_any);
  endproperty
  a_lock: assert property (p_lock) else $error("lock low without phase error");
  property p_vco_mon;
    divided_vco_monitor |=> !divided_vco_monitor [*8];
  endproperty
  a_vco_mon: assert property (p_vco_mon) else $error("vco monitor pulse too long");
  property p_ref_mon;
    divided_reference_monitor |=> !divided_reference_monitor [*8];
  endproperty
  a_ref_mon: assert property (p_ref_mon) else $error("ref monitor pulse too long");

  c_up: cover property (ext_pump_ref);
  c_down: cover property (ext_pump_vco);
  c_slverr: cover property (pslverr);
  c_vco: cover property (divided_vco_monitor);
endmodule

bind serial_pll_divider_control pll_ctl_props u_props (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .serial_clk, .serial_data, .load_strobe, .vco_input,
  .reference_oscillator_input, .reference_inverter_output, .pump_passive, .pump_active,
  .lock_indicator_out, .divided_vco_monitor, .divided_reference_monitor,
  .ext_pump_ref, .ext_pump_vco
);

// ---- dv/host_link_model.sv ----
`timescale 1ns/1ns
module host_link_model (
  // Serial programming link
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  initial
  begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // ------------------------------
  // Word transmitter
  // ------------------------------
  // Clock parks low between words; afterwards data shows the inverse of
  // its last bit so a stale level cannot pass for a fresh one
  task automatic send(input logic [15:0] value, input logic sel, input logic load);
    logic [16:0] word;
    word = {value, sel};
    // Step off the pclk edge so no pin changes in the instant it is sampled
    #5;
    for (int i = 16; i >= 0; i--)
    begin
      serial_data = word[i];
      #200 serial_clk = 1'b1;
      #200 serial_clk = 1'b0;
    end
    #100 load_strobe = load;
    #400 load_strobe = 1'b0;
    serial_data = ~word[0];
    #200;
  endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
  localparam int LIMIT = 90000;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             ce = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             serial_clk;
  logic             serial_data;
  logic             load_strobe;
  logic             vco_input = 1'b0;
  logic             reference_oscillator_input = 1'b0;
  logic             reference_inverter_output;
  synth_pkg::pump_t pump_passive;
  synth_pkg::pump_t pump_active;
  logic             lock_indicator_out;
  logic             divided_vco_monitor;
  logic             divided_reference_monitor;
  logic             ext_pump_ref;
  logic             ext_pump_vco;
  logic [15:0]      m_ref = 16'h0005;
  logic [15:0]      m_vco = 16'h0140;
  logic             m_stby = 1'b1;
  logic [1:0]       m_ctl = 2'h2;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int up_cyc = 0;
  int dn_cyc = 0;
  int oe_cyc = 0;
  int lock_lo = 0;
  int vco_cnt = 0;

  host_link_model host (.serial_clk, .serial_data, .load_strobe);
  serial_pll_divider_control dut (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_clk, .serial_data, .load_strobe, .vco_input,
    .reference_oscillator_input, .reference_inverter_output, .pump_passive, .pump_active,
    .lock_indicator_out, .divided_vco_monitor, .divided_reference_monitor,
    .ext_pump_ref, .ext_pump_vco
  );

  // ------------------------------
  // Clocks, sources and counters
  // ------------------------------
  // Periods are whole pclk multiples so synced edge spacing is exact
  always #25 pclk = ~pclk;
  initial
  begin
    #13;
    forever #125 vco_input = ~vco_input;
  end
  initial
  begin
    #7;
    forever #150 reference_oscillator_input = ~reference_oscillator_input;
  end
  always @(posedge pclk)
  begin
    cyc++;
    up_cyc += (ext_pump_ref === 1'b1);
    dn_cyc += (ext_pump_vco === 1'b1);
    oe_cyc += (pump_passive.oe === 1'b1 || pump_active.oe === 1'b1);
    lock_lo += (lock_indicator_out === 1'b0);
    vco_cnt += (divided_vco_monitor === 1'b1);
    if (cyc == LIMIT)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] mask,
                        input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    cmp(what, exp, rd & mask);
  endtask

  task automatic wr_ctl(input logic [1:0] v);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, synth_pkg::CONTROL_OFF, {30'h0, v}, rd, er);
    m_ctl = v;
  endtask

  task automatic load(input logic [15:0] v, input logic s);
    host.send(v, s, 1'b1);
    @(posedge pclk);
    m_stby = (v == 16'h0000);
    if (s)
      m_ref = v;
    else
      m_vco = v;
  endtask

  task automatic check_regs();
    rd_chk(synth_pkg::REF_OFF, 32'hffff, {16'h0, m_ref}, "ref_ratio");
    rd_chk(synth_pkg::VCO_OFF, 32'hffff, {16'h0, m_vco}, "vco_set");
    rd_chk(synth_pkg::STATUS_OFF, 32'h2, {30'h0, m_stby | m_ctl[0], 1'b0}, "stby");
  endtask

  // Edges between two successive monitor pulses
  task automatic gap(input logic v, output int n);
    n = 0;
    while ((v ? divided_vco_monitor : divided_reference_monitor) !== 1'b1)
      @(posedge pclk);
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((v ? divided_vco_monitor : divided_reference_monitor) !== 1'b1);
  endtask

  task automatic watch(input int cycles);
    // Clear off the edge so the counting process cannot race the reset
    @(negedge pclk);
    up_cyc = 0;
    dn_cyc = 0;
    oe_cyc = 0;
    lock_lo = 0;
    vco_cnt = 0;
    repeat (cycles) @(posedge pclk);
  endtask

  task automatic stby_chk();
    rd_chk(synth_pkg::STATUS_OFF, 32'h2, 32'h2, "standby");
    watch(3000);
    cmp("stby_pulses", 32'h0, vco_cnt);
    cmp("ref_inv_low", 32'h0, reference_inverter_output);
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    logic [31:0] rd;
    logic        er;
    int          n;
    int          nn;
    int          aa;
    int          rr;
    void'($urandom(5));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(synth_pkg::CONTROL_OFF, 32'hffffffff, 32'h2, "control");
    rd_chk(synth_pkg::STATUS_OFF, 32'h3, 32'h3, "status_rst");
    check_regs();
    apb(1'b0, 12'h010, 32'h0, rd, er);
    cmp("unmapped_err", 32'h1, er);
    cmp("unmapped_data", 32'h0, rd);
    apb(1'b1, synth_pkg::REF_OFF, 32'h1234, rd, er);
    check_regs();
    host.send(16'h0064, 1'b1, 1'b0);
    @(posedge pclk);
    check_regs();
    load(16'h0064, 1'b1);
    check_regs();
    // Ratios stay at five or above and main above swallow
    for (int k = 0; k < 3; k++)
    begin
      nn = (k == 0) ? 5 : 5 + $urandom_range(3);
      aa = (k == 0) ? 4 : $urandom_range(nn - 1);
      rr = (k == 0) ? 5 : 5 + $urandom_range(60);
      load(16'(nn * 64 + aa), 1'b0);
      load(16'(rr), 1'b1);
      check_regs();
      gap(1'b1, n);
      cmp("vco_gap", 5 * (nn * 64 + aa), n);
      gap(1'b0, n);
      cmp("ref_gap", 6 * rr, n);
    end
    load(16'h0140, 1'b0);
    load(16'h0005, 1'b1);
    watch(4000);
    cmp("ref_leads", 32'h1, up_cyc > dn_cyc);
    cmp("lock_pulses", 32'h1, lock_lo > 0);
    load(16'h0258, 1'b1);
    watch(8000);
    cmp("vco_leads", 32'h1, dn_cyc > up_cyc);
    wr_ctl(2'h0);
    watch(4000);
    cmp("pump_off", 32'h0, oe_cyc);
    wr_ctl(2'h3);
    rd_chk(synth_pkg::CONTROL_OFF, 32'hffffffff, 32'h3, "control_rw");
    stby_chk();
    wr_ctl(2'h2);
    load(16'h0000, 1'b0);
    stby_chk();
    load(16'h0144, 1'b0);
    check_regs();
    gap(1'b1, n);
    cmp("vco_gap_wake", 32'd1620, n);
    // Freeze right after a monitor pulse so the held level is low
    ce <= 1'b0;
    watch(2000);
    cmp("ce_freeze", 32'h0, vco_cnt);
    ce <= 1'b1;
    gap(1'b1, n);
    cmp("vco_gap_ce", 32'd1620, n);
    wrap_up();
  end
endmodule
